// File: hdl/bme_regs.vh
// Purpose: Shared constants of the byte move executor
// Assumes: Included by bare name from the design files
// Notes: Byte offsets on a 32-bit AHB-Lite register bus
`ifndef BME_REGS_VH
`define BME_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BME_OFS_CMD 8'h00
`define BME_OFS_OPND 8'h04
`define BME_OFS_STATUS 8'h08
`define BME_OFS_FLAGS 8'h0C
`define BME_OFS_GREG0 8'h20
`define BME_OFS_GREG7 8'h3C

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define BME_CMD_MODE_LSB 0
`define BME_CMD_DREG_LSB 4
`define BME_CMD_SREG_LSB 8
`define BME_CMD_AREG_LSB 12
`define BME_CMD_WIDTH 15

// Condition flag positions
`define BME_FLG_C 0
`define BME_FLG_V 1
`define BME_FLG_Z 2
`define BME_FLG_N 3

// Reset values
`define BME_RST_FLAGS 8'h00
`define BME_RST_GREG 32'h0000_0000

// ----------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------
`define BME_M_IMM 4'h0
`define BME_M_REG 4'h1
`define BME_M_IND_LD 4'h2
`define BME_M_D16_LD 4'h3
`define BME_M_D24_LD 4'h4
`define BME_M_INC_LD 4'h5
`define BME_M_A8_LD 4'h6
`define BME_M_A16_LD 4'h7
`define BME_M_A24_LD 4'h8
`define BME_M_IND_ST 4'h9
`define BME_M_D16_ST 4'hA
`define BME_M_D24_ST 4'hB
`define BME_M_DEC_ST 4'hC
`define BME_M_A8_ST 4'hD
`define BME_M_A16_ST 4'hE
`define BME_M_A24_ST 4'hF

// Short absolute page base
`define BME_A8_BASE 32'hFFFF_FF00

`endif

// File: hdl/bme_gregs.v
// Purpose: General register file, eight 32-bit registers
// Assumes: Single clock, asynchronous active-low reset
// Notes: Three combinational read ports, one word and one byte write
`timescale 1ns/1ps
`include "bme_regs.vh"

module bme_gregs #(
  parameter NREG = 8
) (
  input wire clk,
  input wire resetn,
  input wire [2:0] rd_a_idx,
  output wire [31:0] rd_a_data,
  input wire [2:0] rd_b_idx,
  output wire [31:0] rd_b_data,
  input wire [2:0] rd_c_idx,
  output wire [31:0] rd_c_data,
  input wire wr32_en,
  input wire [2:0] wr32_idx,
  input wire [31:0] wr32_data,
  input wire wr8_en,
  input wire [3:0] wr8_idx,
  input wire [7:0] wr8_data
);

  reg [31:0] greg_ff [0:NREG-1];
  integer i;

  assign rd_a_data = greg_ff[rd_a_idx];
  assign rd_b_data = greg_ff[rd_b_idx];
  assign rd_c_data = greg_ff[rd_c_idx];

  // ----------------------------------------------------------------
  // Write: byte lands over word so a shared register keeps both
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < NREG; i = i + 1) begin
        greg_ff[i] <= `BME_RST_GREG;
      end
    end else begin
      for (i = 0; i < NREG; i = i + 1) begin
        if (wr8_en && (wr8_idx[2:0] == i[2:0])) begin
          // Only one half changes; rest of the word kept unless the word write hits this register too
          if (wr8_idx[3]) begin
            greg_ff[i] <= {(wr32_en && wr32_idx == i[2:0]) ?
                           wr32_data[31:8] : greg_ff[i][31:8],
                           wr8_data};
          end else begin
            greg_ff[i] <= {(wr32_en && wr32_idx == i[2:0]) ?
                           wr32_data[31:16] : greg_ff[i][31:16],
                           wr8_data,
                           (wr32_en && wr32_idx == i[2:0]) ?
                           wr32_data[7:0] : greg_ff[i][7:0]};
          end
        end else if (wr32_en && (wr32_idx == i[2:0])) begin
          greg_ff[i] <= wr32_data;
        end
      end
    end
  end

endmodule // bme_gregs

// File: hdl/bme_core.v
// Purpose: Executes byte moves between registers, immediates, memory
// Assumes: AHB-Lite slave for control, same-clock memory handshake
// Notes: One wait state on reads, none on writes; OKAY always
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bme_regs.vh"

module bme_core (
  input wire clk,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout_ff,
  output reg hresp_ff,
  output reg [31:0] hrdata_ff,
  output reg mem_req_ff,
  output reg mem_we_ff,
  output reg [31:0] mem_addr_ff,
  output reg [7:0] mem_wdata_ff,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  output reg busy_ff
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function [3:0] f_len;
    input [3:0] m;
    begin
      case (m)
        `BME_M_D16_LD, `BME_M_A16_LD,
        `BME_M_D16_ST, `BME_M_A16_ST: f_len = 4'h4;
        `BME_M_D24_LD, `BME_M_D24_ST: f_len = 4'h8;
        `BME_M_A24_LD, `BME_M_A24_ST: f_len = 4'h6;
        default: f_len = 4'h2;
      endcase
    end
  endfunction

  function [3:0] f_states;
    input [3:0] m;
    begin
      case (m)
        `BME_M_IMM, `BME_M_REG: f_states = 4'h2;
        `BME_M_IND_LD, `BME_M_A8_LD,
        `BME_M_IND_ST, `BME_M_A8_ST: f_states = 4'h4;
        `BME_M_A24_LD, `BME_M_A24_ST: f_states = 4'h8;
        `BME_M_D24_LD, `BME_M_D24_ST: f_states = 4'hA;
        default: f_states = 4'h6;
      endcase
    end
  endfunction

  // Index 0-7 high half, 8-15 low half
  function [7:0] f_byte;
    input [31:0] r;
    input [3:0] idx;
    begin
      f_byte = idx[3] ? r[7:0] : r[15:8];
    end
  endfunction

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_CALC = 3'b010;
  localparam [2:0] S_MEM = 3'b100;
  localparam [3:0] S_DONE_CODE = 4'h0;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0] state_ff;
  reg fin_ff;
  reg [3:0] cnt_ff;
  reg [`BME_CMD_WIDTH-1:0] cmd_ff;
  reg [31:0] opnd_ff;
  reg [7:0] flags_ff;
  reg [7:0] val_ff;
  reg done_ff;
  reg [7:0] bus_addr_ff;
  reg bus_wr_ff;
  reg bus_rd_ff;

  wire [3:0] mode = cmd_ff[`BME_CMD_MODE_LSB +: 4];
  wire [3:0] dreg = cmd_ff[`BME_CMD_DREG_LSB +: 4];
  wire [3:0] sreg = cmd_ff[`BME_CMD_SREG_LSB +: 4];
  wire [2:0] areg = cmd_ff[`BME_CMD_AREG_LSB +: 3];
  wire is_store = mode[3] & (mode != `BME_M_A24_LD);
  wire is_mem = (mode != `BME_M_IMM) && (mode != `BME_M_REG);

  wire [31:0] rd_a_data;
  wire [31:0] rd_b_data;
  wire [31:0] rd_c_data;
  wire [2:0] rd_b_idx = (mode == `BME_M_REG) ? sreg[2:0] : dreg[2:0];
  wire [7:0] data_byte =
    f_byte(rd_b_data, (mode == `BME_M_REG) ? sreg : dreg);

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  reg [31:0] ea;
  always @* begin
    case (mode)
      `BME_M_D16_LD, `BME_M_D16_ST:
        ea = rd_a_data + {{16{opnd_ff[15]}}, opnd_ff[15:0]};
      `BME_M_D24_LD, `BME_M_D24_ST:
        ea = rd_a_data + {{8{opnd_ff[23]}}, opnd_ff[23:0]};
      `BME_M_DEC_ST:
        ea = rd_a_data - 32'h0000_0001;
      `BME_M_A8_LD, `BME_M_A8_ST:
        ea = `BME_A8_BASE | {24'h00_0000, opnd_ff[7:0]};
      `BME_M_A16_LD, `BME_M_A16_ST:
        ea = {{16{opnd_ff[15]}}, opnd_ff[15:0]};
      `BME_M_A24_LD, `BME_M_A24_ST:
        ea = {8'h00, opnd_ff[23:0]};
      default:
        ea = rd_a_data; // Whole 32-bit register as pointer
    endcase
  end

  // ----------------------------------------------------------------
  // Register file write steering
  // ----------------------------------------------------------------
  wire bus_take = hsel & htrans[1] & hready;
  wire greg_hit = (bus_addr_ff >= `BME_OFS_GREG0) &&
                  (bus_addr_ff <= `BME_OFS_GREG7);
  wire bus_wr_now = bus_wr_ff & ~busy_ff;

  reg wr32_en;
  reg [2:0] wr32_idx;
  reg [31:0] wr32_data;
  reg wr8_en;
  reg [7:0] wr8_data;
  always @* begin
    wr32_en = 1'b0;
    wr32_idx = areg;
    wr32_data = ea;
    wr8_en = 1'b0;
    wr8_data = mem_rdata;
    if (state_ff == S_CALC) begin
      if (mode == `BME_M_DEC_ST) begin
        wr32_en = 1'b1; // Pointer drops before the write
      end
      if (mode == `BME_M_IMM) begin
        wr8_en = 1'b1;
        wr8_data = opnd_ff[7:0];
      end else if (mode == `BME_M_REG) begin
        wr8_en = 1'b1;
        wr8_data = data_byte;
      end
    end else if ((state_ff == S_MEM) && mem_ack && !is_store) begin
      wr8_en = 1'b1;
      if (mode == `BME_M_INC_LD) begin
        wr32_en = 1'b1; // Step after the read
        wr32_data = rd_a_data + 32'h0000_0001;
      end
    end else if (bus_wr_now && greg_hit) begin
      wr32_en = 1'b1;
      wr32_idx = bus_addr_ff[4:2];
      wr32_data = hwdata;
    end
  end

  bme_gregs #(
    .NREG(8)
  ) u_gregs (
    .clk(clk),
    .resetn(resetn),
    .rd_a_idx(areg),
    .rd_a_data(rd_a_data),
    .rd_b_idx(rd_b_idx),
    .rd_b_data(rd_b_data),
    .rd_c_idx(bus_addr_ff[4:2]),
    .rd_c_data(rd_c_data),
    .wr32_en(wr32_en),
    .wr32_idx(wr32_idx),
    .wr32_data(wr32_data),
    .wr8_en(wr8_en),
    .wr8_idx(dreg),
    .wr8_data(wr8_data)
  );

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  wire start = bus_wr_now && (bus_addr_ff == `BME_OFS_CMD);
  wire fin_now = fin_ff &&
                 ({1'b0, cnt_ff} + 5'h01 >= {1'b0, f_states(mode)});

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      fin_ff <= 1'b0;
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      val_ff <= 8'h00;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
      mem_wdata_ff <= 8'h00;
    end else begin
      if (busy_ff && (cnt_ff != 4'hF)) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            state_ff <= S_CALC;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
            fin_ff <= 1'b0;
            cnt_ff <= 4'h0;
          end
        end
        S_CALC: begin
          if (is_mem) begin
            state_ff <= S_MEM;
            mem_req_ff <= 1'b1;
            mem_we_ff <= is_store;
            mem_addr_ff <= ea;
            mem_wdata_ff <= data_byte;
            val_ff <= data_byte;
          end else begin
            state_ff <= S_IDLE;
            fin_ff <= 1'b1;
            val_ff <= (mode == `BME_M_IMM) ? opnd_ff[7:0] : data_byte;
          end
        end
        S_MEM: begin
          if (mem_ack) begin
            state_ff <= S_IDLE;
            fin_ff <= 1'b1;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            if (!is_store) begin
              val_ff <= mem_rdata;
            end
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
      // Hold busy until the instruction's state count has elapsed
      if (fin_now) begin
        fin_ff <= 1'b0;
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command, operand and condition flags
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ff <= {`BME_CMD_WIDTH{1'b0}};
      opnd_ff <= 32'h0000_0000;
      flags_ff <= `BME_RST_FLAGS;
    end else begin
      if (start) begin
        cmd_ff <= hwdata[`BME_CMD_WIDTH-1:0];
      end
      if (bus_wr_now && (bus_addr_ff == `BME_OFS_OPND)) begin
        opnd_ff <= hwdata;
      end
      if (fin_now) begin
        flags_ff[`BME_FLG_N] <= val_ff[7];
        flags_ff[`BME_FLG_Z] <= (val_ff == 8'h00);
        flags_ff[`BME_FLG_V] <= 1'b0;
        // Carry bit not assigned here, so it keeps its value
      end else if (bus_wr_now && (bus_addr_ff == `BME_OFS_FLAGS)) begin
        flags_ff <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    case (bus_addr_ff)
      `BME_OFS_CMD: rd_mux = {{(32-`BME_CMD_WIDTH){1'b0}}, cmd_ff};
      `BME_OFS_OPND: rd_mux = opnd_ff;
      `BME_OFS_STATUS:
        rd_mux = {16'h0000, f_states(mode), f_len(mode),
                  6'h00, done_ff, busy_ff};
      `BME_OFS_FLAGS: rd_mux = {24'h00_0000, flags_ff};
      default: rd_mux = greg_hit ? rd_c_data : 32'h0000_0000;
    endcase
  end

  // Reads take one wait state so a write just before is seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      bus_addr_ff <= 8'h00;
      bus_wr_ff <= 1'b0;
      bus_rd_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      if (bus_rd_ff) begin
        hrdata_ff <= rd_mux;
        hreadyout_ff <= 1'b1;
        bus_rd_ff <= 1'b0;
      end else if (bus_take) begin
        bus_addr_ff <= (haddr[31:8] == 24'h00_0000) ?
                       {haddr[7:2], 2'b00} : 8'hFC;
        bus_wr_ff <= hwrite;
        bus_rd_ff <= ~hwrite;
        hreadyout_ff <= hwrite;
      end else begin
        bus_wr_ff <= 1'b0;
      end
    end
  end

endmodule // bme_core

// File: verification/bme_core_monitor.sv
// Purpose: Port-level checks of the byte move executor
// Assumes: Bound to bme_core; one clock, reset active low
// Notes: Memory timing is judged by handshake, not by fixed counts
`timescale 1ns/1ps
`include "bme_regs.vh"

module bme_core_monitor (
  input wire clk,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire mem_req_ff,
  input wire mem_we_ff,
  input wire [31:0] mem_addr_ff,
  input wire [7:0] mem_wdata_ff,
  input wire mem_ack,
  input wire busy_ff
);
  reg cmd_wr_ff;
  wire take = hsel && htrans[1] && hready;

  // ----------------------------------------------------------------
  // Command write seen in its address phase
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) cmd_wr_ff <= 1'b0;
    else cmd_wr_ff <= take && hwrite && haddr == `BME_OFS_CMD;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_rd_wait;
    take && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read not answered after one wait");
  property p_wr_nowait;
    take && hwrite |=> hreadyout_ff;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  property p_okay;
    !hresp_ff;
  endproperty
  a_okay: assert property (p_okay)
    else $error("error response");
  property p_start;
    cmd_wr_ff && !busy_ff |=> busy_ff;
  endproperty
  a_start: assert property (p_start)
    else $error("command write did not start a move");
  property p_req_busy;
    mem_req_ff |-> busy_ff;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("memory request outside a move");
  property p_req_hold;
    mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff)
      && $stable(mem_we_ff);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request dropped before ack");
  property p_wdata_hold;
    mem_req_ff && mem_we_ff && !mem_ack |=> $stable(mem_wdata_ff);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("store byte changed before ack");
  property p_req_drop;
    mem_req_ff && mem_ack |=> !mem_req_ff;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("memory request held after ack");
  property p_busy_end;
    $fell(mem_req_ff) |-> ##[0:9] !busy_ff;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("move did not finish after memory ack");
endmodule // bme_core_monitor

bind bme_core bme_core_monitor mon (.clk(clk), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
  .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff),
  .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
  .mem_ack(mem_ack), .busy_ff(busy_ff));

// File: verification/bme_mem_model.sv
// Purpose: Byte memory on the far side of the executor
// Assumes: Same clock; ack after a programmable wait
// Notes: Read data toggles while idle so stale bytes never match
`timescale 1ns/1ps

module bme_mem_model (
  input wire clk,
  input wire resetn,
  input wire [3:0] dly,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] m [0:255];
  logic [31:0] last_addr;
  logic [7:0] last_wdata;
  logic [3:0] cnt;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 8'hA5;
      last_addr <= 32'h0;
      last_wdata <= 8'h00;
    end else if (mem_req && !mem_ack && cnt >= dly) begin
      mem_ack <= 1'b1;
      mem_rdata <= m[mem_addr[7:0]];
      last_addr <= mem_addr;
      if (mem_we) begin
        m[mem_addr[7:0]] <= mem_wdata;
        last_wdata <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // bme_mem_model

// File: verification/byte_move_execution_test.sv
// Purpose: Self-checking bench for the byte move executor
// Assumes: bme_core with the memory model on its far side
// Notes: Flags, addresses and bytes are worked out here
`timescale 1ns/1ps
`include "bme_regs.vh"

module byte_move_execution_test;
  logic clk, resetn, hsel, hwrite, mem_ack;
  logic hreadyout_ff, hresp_ff, mem_req_ff, mem_we_ff, busy_ff;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] dly;
  logic [7:0] mem_wdata_ff, mem_rdata;
  logic [31:0] haddr, hwdata, hrdata_ff, mem_addr_ff, q;
  integer errors = 0;
  integer n_checks = 0;

  bme_core dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_ff), .hreadyout_ff(hreadyout_ff),
    .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .busy_ff(busy_ff));
  bme_mem_model mem (.clk(clk), .resetn(resetn), .dly(dly),
    .mem_req(mem_req_ff), .mem_we(mem_we_ff), .mem_addr(mem_addr_ff),
    .mem_wdata(mem_wdata_ff), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // Single word transfer; read data lands in q
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout_ff !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout_ff !== 1'b1) @(posedge clk);
    q = hrdata_ff;
  endtask

  function automatic logic [31:0] ga(input int n);
    ga = `BME_OFS_GREG0 + 4 * n;
  endfunction

  // Flags preset with V set and C from the byte, then one move
  task automatic mv(input logic [14:0] c, input logic [31:0] op,
                    input logic [7:0] b, ls);
    integer n;
    bus(1'b1, `BME_OFS_FLAGS, {24'h0, 4'hA, 3'h1, b[0]});
    bus(1'b1, `BME_OFS_OPND, op);
    bus(1'b1, `BME_OFS_CMD, {17'h0, c});
    n = 0;
    do begin
      bus(1'b0, `BME_OFS_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
    chk("status", {16'h0, ls, 8'h02}, q & 32'h0000FF03);
    bus(1'b0, `BME_OFS_FLAGS, 32'h0);
    chk("flags", {24'h0, 4'hA, b[7], b == 8'h00, 1'b0, b[0]}, q);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    resetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    dly <= 4'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    mem.m[8'h40] = 8'h5A;
    mem.m[8'h70] = 8'hC3;
    mem.m[8'hFF] = 8'h00;
    @(posedge clk);
    bus(1'b0, `BME_OFS_FLAGS, 32'h0);
    chk("flags_rst", 32'h0, q);
    bus(1'b0, 32'h0000_0080, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, ga(1), 32'h1234_5678);
    bus(1'b1, ga(2), 32'h1234_0150);
    bus(1'b1, ga(4), 32'h0000_01FF);
    bus(1'b1, ga(5), 32'h5555_5555);
    bus(1'b1, ga(6), 32'h0001_0000);
    mv(15'h0010, 32'h0000_00AB, 8'hAB, 8'h22);
    bus(1'b0, ga(1), 32'h0);
    chk("er1", 32'h1234_AB78, q);
    mv(15'h0181, 32'h0, 8'hAB, 8'h22);
    bus(1'b0, ga(0), 32'h0);
    chk("er0", 32'h0000_00AB, q);
    mv(15'h20B3, 32'h0000_FFF0, 8'h5A, 8'h64);
    chk("d16_addr", 32'h1234_0140, mem.last_addr);
    dly <= 4'h3;
    mv(15'h2034, 32'h0000_0020, 8'hC3, 8'hA8);
    chk("d24_addr", 32'h1234_0170, mem.last_addr);
    bus(1'b0, ga(3), 32'h0);
    chk("er3", 32'h0000_C35A, q);
    dly <= 4'h0;
    mv(15'h40D5, 32'h0, 8'h00, 8'h62);
    chk("inc_addr", 32'h0000_01FF, mem.last_addr);
    bus(1'b0, ga(4), 32'h0);
    chk("er4", 32'h0000_0200, q);
    bus(1'b0, ga(5), 32'h0);
    chk("er5", 32'h5555_5500, q);
    mv(15'h60BC, 32'h0, 8'h5A, 8'h62);
    chk("dec_addr", 32'h0000_FFFF, mem.last_addr);
    chk("dec_byte", 32'h5A, {24'h0, mem.m[8'hFF]});
    bus(1'b0, ga(6), 32'h0);
    chk("er6", 32'h0000_FFFF, q);
    mv(15'h603A, 32'h0000_8000, 8'hC3, 8'h64);
    chk("d16s_addr", 32'h0000_7FFF, mem.last_addr);
    chk("d16s_byte", 32'hC3, {24'h0, mem.last_wdata});
    dly <= 4'h2;
    mv(15'h209B, 32'h00FF_FFFF, 8'h78, 8'hA8);
    chk("d24s_addr", 32'h1234_014F, mem.last_addr);
    chk("d24s_byte", 32'h78, {24'h0, mem.last_wdata});
    mv(15'h2019, 32'h0, 8'hAB, 8'h42);
    chk("ind_st", 32'h1234_0150, mem.last_addr);
    chk("ind_sb", 32'hAB, {24'h0, mem.last_wdata});
    mv(15'h20F2, 32'h0, 8'hAB, 8'h42);
    mv(15'h005D, 32'h0000_0033, 8'h55, 8'h42);
    chk("a8s_addr", 32'hFFFF_FF33, mem.last_addr);
    mv(15'h0076, 32'h0000_0033, 8'h55, 8'h42);
    bus(1'b0, ga(7), 32'h0);
    chk("er7", 32'h0000_55AB, q);
    mv(15'h00BE, 32'h0000_9010, 8'h5A, 8'h64);
    chk("a16s_addr", 32'hFFFF_9010, mem.last_addr);
    mv(15'h00E7, 32'h0000_1010, 8'h5A, 8'h64);
    chk("a16_addr", 32'h0000_1010, mem.last_addr);
    bus(1'b0, ga(6), 32'h0);
    chk("er6b", 32'h0000_FF5A, q);
    mv(15'h003F, 32'h80AB_CD20, 8'hC3, 8'h86);
    chk("a24s_addr", 32'h00AB_CD20, mem.last_addr);
    mv(15'h00A8, 32'hFF00_0020, 8'hC3, 8'h86);
    chk("a24_addr", 32'h0000_0020, mem.last_addr);
    bus(1'b0, ga(2), 32'h0);
    chk("er2", 32'h1234_01C3, q);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule // byte_move_execution_test
